// ===== src/dcc_pkg.sv
package dcc_pkg;
  // register port address map
  localparam logic [2:0] DCC_ADDR_CTRL    = 3'h0;
  localparam logic [2:0] DCC_ADDR_FLAG    = 3'h1;
  localparam logic [2:0] DCC_ADDR_ENABLE  = 3'h2;
  localparam logic [2:0] DCC_ADDR_IRQCTL  = 3'h3;
  localparam logic [2:0] DCC_ADDR_DIR     = 3'h4;
  // control register fields
  localparam int DCC_BIT_TWO_RESULT = 7;
  localparam int DCC_BIT_ONE_RESULT = 6;
  localparam int DCC_BIT_TWO_INV    = 5;
  localparam int DCC_BIT_ONE_INV    = 4;
  localparam int DCC_BIT_SWITCH     = 3;
  localparam int DCC_MODE_LSB       = 0;
  localparam logic [7:0] DCC_CTRL_RESET = 8'h07;
  // interrupt and direction bit positions
  localparam int DCC_BIT_FLAG       = 6;
  localparam int DCC_BIT_CMP_EN     = 6;
  localparam int DCC_BIT_PERIPH_EN  = 6;
  localparam int DCC_BIT_GLOBAL_EN  = 7;
  localparam int DCC_BIT_DIR_ONE    = 4;
  localparam int DCC_BIT_DIR_TWO    = 5;
  localparam logic [7:0] DCC_REG_RESET = 8'h00;
  localparam logic [7:0] DCC_DIR_RESET = 8'hFF;
  // modes
  localparam logic [2:0] DCC_MODE_MUX4 = 3'h6;
  localparam logic [2:0] DCC_MODE_OFF  = 3'h7;
  // routing table entry: {pin_out_en, cmp2_on, cmp1_on}
  localparam logic [23:0] DCC_ROUTE_TABLE = 24'h3B6DB3;
endpackage : dcc_pkg

// ===== src/dcc_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser for one level
module dcc_sync
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // level
  input  wire logic d,
  output logic      q
);
  logic meta_reg;

  // first stage read only by second stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : dcc_sync

// ===== src/dcc_ctrl.sv
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/100ps
// Behaviour
// RULE1: uninverted result is high when positive input exceeds negative input
// RULE2: invert bit complements result on register bit and pin
// RULE3: result bits 7 and 6 are read only, writes ignore them
// RULE4: three-bit mode field selects one of eight configurations
// RULE5: in mode 110 switch bit steers negative inputs to ref pins
// RULE6: internal reference on positive inputs only in mode 110
// RULE7: pin outputs carry unsynchronised results when mode enables them
// RULE8: direction bits remain output enables of the two pins
// RULE9: flag is set whenever either comparator output changes
// RULE10: any control register access latches current outputs
// RULE11: persisting mismatch keeps setting the flag
// RULE12: writing zero clears flag, writing one sets it
// RULE13: request only with all three enables; flag set regardless
// RULE14: change during a read sample may miss the flag
// RULE15: comparators run in sleep and enabled interrupt wakes
// RULE16: reset gives mode 111, other control bits zero
// RULE17: wake from sleep leaves control register unchanged
// RULE18: software masks the interrupt while changing mode
// RULE19: software selects mode 111 before sleep
// RULE20: results pass two-stage synchroniser before register and mismatch
// RULE21: routing of other modes comes from a configurable table
module dcc_ctrl
  import dcc_pkg::*;
#(
  parameter logic [23:0] ROUTE_TABLE = DCC_ROUTE_TABLE
)
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  // raw analog comparator results
  input  wire logic       cmp_one_raw,
  input  wire logic       cmp_two_raw,
  // analog steering controls
  output logic            cmp_one_power,
  output logic            cmp_two_power,
  output logic            neg_to_ref_pins,
  output logic            pos_to_internal_ref,
  // pins
  output logic            cmp_one_out_pin,
  output logic            cmp_two_out_pin,
  output logic            cmp_one_pin_oe,
  output logic            cmp_two_pin_oe,
  output logic            pin_mux_sel,
  // interrupt and wake
  output logic            irq_req,
  output logic            wake_req
);
  logic       rst_meta_reg;
  logic       rst_sync_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] flag_reg;
  logic [7:0] enable_reg;
  logic [7:0] irqctl_reg;
  logic [7:0] dir_reg;
  logic [1:0] latched_reg;
  logic [7:0] rdata_reg;
  logic       one_sync;
  logic       two_sync;

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // synchronise analog results
  dcc_sync u_sync_one (.clk(clk), .rst_n(rst_sync_reg), // RULE20
                       .d(cmp_one_raw), .q(one_sync));
  dcc_sync u_sync_two (.clk(clk), .rst_n(rst_sync_reg),
                       .d(cmp_two_raw), .q(two_sync));

  // decode
  wire [2:0] mode      = ctrl_reg[DCC_MODE_LSB +: 3]; // RULE4
  wire       inv_one   = ctrl_reg[DCC_BIT_ONE_INV];
  wire       inv_two   = ctrl_reg[DCC_BIT_TWO_INV];
  wire       is_mux4   = (mode == DCC_MODE_MUX4);
  wire       is_off    = (mode == DCC_MODE_OFF);
  wire [2:0] route_tab = ROUTE_TABLE[mode*3 +: 3]; // RULE21
  // mode 111 and the comparator power of mode 110 are fixed here, whatever the table says
  wire [2:0] route     = is_off  ? 3'h0 : // RULE16
                         is_mux4 ? {route_tab[2], 2'h3} : route_tab; // RULE6
  wire       hit_ctrl  = (addr == DCC_ADDR_CTRL);
  wire       wr_ctrl   = wr_en && hit_ctrl;
  wire       acc_ctrl  = (wr_en || rd_en) && hit_ctrl; // RULE10
  wire       wr_flag   = wr_en && (addr == DCC_ADDR_FLAG);
  wire       wr_enable = wr_en && (addr == DCC_ADDR_ENABLE);
  wire       wr_irqctl = wr_en && (addr == DCC_ADDR_IRQCTL);
  wire       wr_dir    = wr_en && (addr == DCC_ADDR_DIR);

  // polarity applied results, gated by comparator power
  wire one_live = route[0] & (one_sync ^ inv_one); // RULE1 RULE2
  wire two_live = route[1] & (two_sync ^ inv_two); // RULE2
  wire [1:0] live_out = {two_live, one_live};
  wire mismatch = (live_out != latched_reg); // RULE9 RULE11

  // flag next value: hardware set wins over software clear
  wire flag_sw = wr_flag ? wdata[DCC_BIT_FLAG] : flag_reg[DCC_BIT_FLAG];
  wire flag_hw = mismatch && !acc_ctrl; // RULE14
  wire flag_next = flag_sw | flag_hw; // RULE12 RULE11
  wire irq_next = flag_reg[DCC_BIT_FLAG] & enable_reg[DCC_BIT_CMP_EN]
                  & irqctl_reg[DCC_BIT_PERIPH_EN]
                  & irqctl_reg[DCC_BIT_GLOBAL_EN]; // RULE13
  wire wake_next = flag_reg[DCC_BIT_FLAG]
                   & enable_reg[DCC_BIT_CMP_EN]; // RULE15

  // read mux
  wire [7:0] ctrl_view = {live_out, ctrl_reg[5:0]}; // RULE3
  wire [7:0] rdata_mux =
    (addr == DCC_ADDR_CTRL)   ? ctrl_view  :
    (addr == DCC_ADDR_FLAG)   ? flag_reg   :
    (addr == DCC_ADDR_ENABLE) ? enable_reg :
    (addr == DCC_ADDR_IRQCTL) ? irqctl_reg :
    (addr == DCC_ADDR_DIR)    ? dir_reg    : 8'h00;

  // control register: result bits never stored
  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      ctrl_reg <= DCC_CTRL_RESET; // RULE16
    else if (wr_ctrl)
      ctrl_reg <= {2'b00, wdata[5:0]}; // RULE3 RULE17
  end

  // latch outputs on any control access
  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      latched_reg <= 2'b00;
    else if (acc_ctrl)
      latched_reg <= live_out; // RULE10
  end

  // interrupt and direction registers
  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      flag_reg   <= DCC_REG_RESET;
      enable_reg <= DCC_REG_RESET;
      irqctl_reg <= DCC_REG_RESET;
      dir_reg    <= DCC_DIR_RESET;
    end
    else
    begin
      flag_reg[DCC_BIT_FLAG] <= flag_next; // RULE9
      if (wr_enable)
        enable_reg[DCC_BIT_CMP_EN] <= wdata[DCC_BIT_CMP_EN];
      if (wr_irqctl)
        irqctl_reg[7:6] <= wdata[7:6];
      if (wr_dir)
        dir_reg[5:4] <= wdata[5:4];
    end
  end

  // registered read data, zero outside the answer cycle
  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rd_en ? rdata_mux : 8'h00;
  end

  // interrupt request and wake levels
  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      irq_req  <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      irq_req  <= irq_next; // RULE13
      wake_req <= wake_next; // RULE15
    end
  end

  // comparator power and input steering
  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      cmp_one_power       <= 1'b0;
      cmp_two_power       <= 1'b0;
      neg_to_ref_pins     <= 1'b0;
      pos_to_internal_ref <= 1'b0;
    end
    else
    begin
      cmp_one_power       <= route[0]; // RULE4
      cmp_two_power       <= route[1];
      neg_to_ref_pins     <= is_mux4 & ctrl_reg[DCC_BIT_SWITCH]; // RULE5
      pos_to_internal_ref <= is_mux4; // RULE6
    end
  end

  // pin multiplexer select and output enables
  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      pin_mux_sel    <= 1'b0;
      cmp_one_pin_oe <= 1'b0;
      cmp_two_pin_oe <= 1'b0;
    end
    else
    begin
      pin_mux_sel    <= route[2]; // RULE7
      cmp_one_pin_oe <= route[2] & ~dir_reg[DCC_BIT_DIR_ONE]; // RULE8
      cmp_two_pin_oe <= route[2] & ~dir_reg[DCC_BIT_DIR_TWO]; // RULE8
    end
  end

  assign rdata = rdata_reg;

  // pin data: raw, unclocked path polarity only, selected by mode
  always_comb
  begin
    cmp_one_out_pin = pin_mux_sel & (cmp_one_raw ^ inv_one); // RULE7 RULE2
    cmp_two_out_pin = pin_mux_sel & (cmp_two_raw ^ inv_two); // RULE7
  end

  // checks
  a_flag_on_mismatch: assert property (@(posedge clk) // RULE11
    disable iff (!rst_sync_reg)
    (mismatch && !acc_ctrl) |=> flag_reg[DCC_BIT_FLAG])
    else $error("flag not set on mismatch");
  a_access_latches: assert property (@(posedge clk) // RULE10
    disable iff (!rst_sync_reg)
    acc_ctrl |=> latched_reg == $past(live_out))
    else $error("access did not latch outputs");
  a_result_ro: assert property (@(posedge clk) // RULE3
    disable iff (!rst_sync_reg)
    (rd_en && hit_ctrl) |=> rdata[7:6] == $past(live_out))
    else $error("result bits not live on read");
  a_irq_gating: assert property (@(posedge clk) // RULE13
    disable iff (!rst_sync_reg)
    irq_req |-> $past(enable_reg[DCC_BIT_CMP_EN] && irqctl_reg[7:6] == 2'b11))
    else $error("irq without enables");
  a_flag_sw_clear: assert property (@(posedge clk) // RULE12
    disable iff (!rst_sync_reg)
    (wr_flag && !wdata[DCC_BIT_FLAG] && !mismatch) |=>
      !flag_reg[DCC_BIT_FLAG])
    else $error("flag not cleared");
  a_flag_sw_set: assert property (@(posedge clk) // RULE12
    disable iff (!rst_sync_reg)
    (wr_flag && wdata[DCC_BIT_FLAG]) |=> flag_reg[DCC_BIT_FLAG])
    else $error("flag not set by write");
  a_ref_mode_only: assert property (@(posedge clk) // RULE6
    disable iff (!rst_sync_reg)
    pos_to_internal_ref |-> $past(mode) == DCC_MODE_MUX4)
    else $error("internal ref outside mode 110");
  a_pin_oe_dir: assert property (@(posedge clk) // RULE8
    disable iff (!rst_sync_reg)
    cmp_one_pin_oe |-> $past(!dir_reg[DCC_BIT_DIR_ONE]))
    else $error("pin enabled against direction");
  a_pin_two_oe_dir: assert property (@(posedge clk) // RULE8
    disable iff (!rst_sync_reg)
    cmp_two_pin_oe |-> $past(!dir_reg[DCC_BIT_DIR_TWO]))
    else $error("pin two enabled against direction");
  a_switch_steer: assert property (@(posedge clk) // RULE5
    disable iff (!rst_sync_reg)
    neg_to_ref_pins |-> $past(is_mux4 && ctrl_reg[DCC_BIT_SWITCH]))
    else $error("negative inputs steered outside mode 110");
  a_off_unpowered: assert property (@(posedge clk) // RULE16
    disable iff (!rst_sync_reg)
    is_off |=> !cmp_one_power && !cmp_two_power)
    else $error("comparator powered in mode 111");
  a_wake_gating: assert property (@(posedge clk) // RULE15
    disable iff (!rst_sync_reg)
    wake_req |-> $past(flag_reg[DCC_BIT_FLAG] && enable_reg[DCC_BIT_CMP_EN]))
    else $error("wake without enabled flag");
  a_pins_quiet: assert property (@(posedge clk) // RULE7
    disable iff (!rst_sync_reg)
    !pin_mux_sel |-> !cmp_one_out_pin && !cmp_two_out_pin)
    else $error("pin driven while mux not selected");
  a_pin_polarity: assert property (@(posedge clk) // RULE2
    disable iff (!rst_sync_reg)
    pin_mux_sel |-> cmp_two_out_pin == (cmp_two_raw ^ inv_two))
    else $error("pin two polarity wrong");
  a_ctrl_write: assert property (@(posedge clk) // RULE17
    disable iff (!rst_sync_reg)
    !wr_ctrl |=> $stable(ctrl_reg))
    else $error("control changed without a write");
  a_read_idle_zero: assert property (@(posedge clk)
    disable iff (!rst_sync_reg)
    !rd_en |=> rdata == 8'h00)
    else $error("read data outside answer cycle");
  c_flag_set: cover property (@(posedge clk) mismatch ##1 flag_reg[6]);
  c_irq: cover property (@(posedge clk) irq_req);
  c_mux4_switch: cover property (@(posedge clk) neg_to_ref_pins);
  c_sw_set: cover property (@(posedge clk) wr_flag && wdata[DCC_BIT_FLAG]);
  c_wake_only: cover property (@(posedge clk) wake_req && !irq_req);
endmodule : dcc_ctrl

// ===== tb/dcc_analog_model.sv
`timescale 1ns/100ps
// behavioural front end: two comparators and their input steering
module dcc_analog_model
(
  // steering from the control block
  input  wire logic       power_one,
  input  wire logic       power_two,
  input  wire logic       neg_to_ref,
  input  wire logic       pos_to_ref,
  // analog levels as unsigned codes
  input  wire logic [7:0] ain [4],
  input  wire logic [7:0] vref,
  // raw comparison results
  output logic            raw_one,
  output logic            raw_two
);
  // input selection; internal reference only on positive inputs
  wire logic [7:0] pos_one = pos_to_ref ? vref : ain[0];
  wire logic [7:0] pos_two = pos_to_ref ? vref : ain[1];
  wire logic [7:0] neg_one = !pos_to_ref ? ain[3] :
                             (neg_to_ref ? ain[3] : ain[0]);
  wire logic [7:0] neg_two = !pos_to_ref ? ain[2] :
                             (neg_to_ref ? ain[2] : ain[1]);
  // high when positive exceeds negative; an unpowered one sits low
  assign raw_one = power_one & (pos_one > neg_one);
  assign raw_two = power_two & (pos_two > neg_two);
endmodule : dcc_analog_model

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench
  import dcc_pkg::*;
;
  localparam logic [23:0] ROUTE = 24'h0FBE50;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  logic [7:0] rdata, d;
  logic       raw_one, raw_two, pw_one, pw_two, neg_ref, pos_ref;
  logic       pin_one, pin_two, oe_one, oe_two, mux_sel, irq_req, wake_req;
  logic [7:0] ain [4] = '{8'h28, 8'h78, 8'hC8, 8'h00};
  logic [7:0] vref = 8'h50;
  int         bad_count = 0;
  int         samples_checked = 0;
  // clock at 25 MHz
  always #20 clk = ~clk;
  dcc_ctrl #(.ROUTE_TABLE(ROUTE)) DUT (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .cmp_one_raw(raw_one), .cmp_two_raw(raw_two),
    .cmp_one_power(pw_one), .cmp_two_power(pw_two),
    .neg_to_ref_pins(neg_ref), .pos_to_internal_ref(pos_ref),
    .cmp_one_out_pin(pin_one), .cmp_two_out_pin(pin_two),
    .cmp_one_pin_oe(oe_one), .cmp_two_pin_oe(oe_two),
    .pin_mux_sel(mux_sel), .irq_req(irq_req), .wake_req(wake_req));
  dcc_analog_model front (.power_one(pw_one), .power_two(pw_two),
    .neg_to_ref(neg_ref), .pos_to_ref(pos_ref), .ain(ain), .vref(vref),
    .raw_one(raw_one), .raw_two(raw_two));
  task automatic close_out;
    if (bad_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask : rd
  // reset values, unmapped address, mode table and steering
  task automatic t_reset_modes;
    rd(DCC_ADDR_CTRL, d);
    chk(d, DCC_CTRL_RESET, "control after reset");
    rd(3'h5, d);
    chk(d, 8'h00, "unmapped read");
    rd(DCC_ADDR_DIR, d);
    chk(d, DCC_DIR_RESET, "direction after reset");
    // interrupts stay disabled while modes change
    for (int m = 0; m < 8; m++)
      for (int s = 0; s < 2; s++)
      begin
        wr(DCC_ADDR_CTRL, {4'h0, s[0], m[2:0]});
        repeat (2) @(posedge clk);
        #1 chk({3'h0, mux_sel, pos_ref, neg_ref, pw_two, pw_one},
          {3'h0, m != 7 && ROUTE[3*m+2], m == 6, m == 6 && s == 1,
           m == 6 || (m != 7 && ROUTE[3*m+1]),
           m == 6 || (m != 7 && ROUTE[3*m])},
          "mode steering");
      end
  endtask : t_reset_modes
  // result bits, inversion and read-only behaviour
  task automatic t_results;
    wr(DCC_ADDR_CTRL, 8'h06);
    repeat (4) @(posedge clk);
    rd(DCC_ADDR_CTRL, d);
    chk(d, 8'h46, "plain results");
    wr(DCC_ADDR_CTRL, 8'hF6);
    repeat (4) @(posedge clk);
    rd(DCC_ADDR_CTRL, d);
    chk(d, 8'hB6, "inverted results, write ignored");
  endtask : t_results
  // unclocked pin path and direction gating
  task automatic t_pins;
    wr(DCC_ADDR_CTRL, 8'h15);
    wr(DCC_ADDR_DIR, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk({6'h0, oe_two, oe_one}, 8'h03, "pin enables");
    chk({6'h0, pin_two, pin_one}, 8'h00, "pin levels");
    @(posedge clk);
    ain[3] <= 8'hFF;
    #1 chk({7'h0, pin_one}, 8'h01, "pin follows without clock");
    wr(DCC_ADDR_DIR, 8'h10);
    repeat (2) @(posedge clk);
    #1 chk({6'h0, oe_two, oe_one}, 8'h02, "pin one as input");
  endtask : t_pins
  // flag setting, persistence, clearing, software set and enables
  task automatic t_irq;
    wr(DCC_ADDR_ENABLE, 8'h40);
    wr(DCC_ADDR_IRQCTL, 8'hC0);
    rd(DCC_ADDR_CTRL, d);
    wr(DCC_ADDR_FLAG, 8'h00);
    repeat (4) @(posedge clk);
    rd(DCC_ADDR_FLAG, d);
    chk(d, 8'h00, "flag quiet without change");
    @(posedge clk);
    ain[2] <= 8'h00;
    repeat (6) @(posedge clk);
    #1 chk({6'h0, wake_req, irq_req}, 8'h03,
           "request on change");
    wr(DCC_ADDR_FLAG, 8'h00);
    repeat (3) @(posedge clk);
    rd(DCC_ADDR_FLAG, d);
    chk(d, 8'h40, "mismatch sets flag again");
    rd(DCC_ADDR_CTRL, d);
    wr(DCC_ADDR_FLAG, 8'h00);
    repeat (4) @(posedge clk);
    rd(DCC_ADDR_FLAG, d);
    chk(d, 8'h00, "access ends mismatch");
    chk({7'h0, irq_req}, 8'h00, "no request when clear");
    wr(DCC_ADDR_FLAG, 8'h40);
    wr(DCC_ADDR_IRQCTL, 8'h40);
    repeat (2) @(posedge clk);
    rd(DCC_ADDR_FLAG, d);
    chk(d, 8'h40, "software set");
    chk({6'h0, wake_req, irq_req}, 8'h02, "global enable off");
    wr(DCC_ADDR_FLAG, 8'h00);
    wr(DCC_ADDR_CTRL, 8'h17);
    repeat (4) @(posedge clk);
    rd(DCC_ADDR_CTRL, d);
    chk(d, 8'h17, "comparators off");
  endtask : t_irq
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset_modes();
    t_results();
    t_pins();
    t_irq();
    close_out();
  end
  // watchdog well beyond the expected run
  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule : testbench
